/* inc/fbim_pkg.sv */
package fbim_pkg;
  localparam int unsigned CLK_HZ            = 50_000_000;
  localparam int unsigned ADDR_W            = 22;
  localparam int unsigned DATA_W            = 16;
  // Timing figures in ns, chosen defaults; counts round up to whole cycles
  localparam int unsigned T_RESET_LOW_NS    = 100;
  localparam int unsigned T_WAKE_VALID_NS   = 600;
  localparam int unsigned T_RESET_WRITE_NS  = 1000;
  localparam int unsigned T_SETUP_NS        = 60;
  localparam int unsigned T_STROBE_NS       = 80;
  localparam int unsigned T_ACCESS_NS       = 120;
  localparam int unsigned NS_PER_S          = 1_000_000_000;
  localparam int unsigned RESET_LOW_CYC  =
    (T_RESET_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned WAKE_VALID_CYC =
    (T_WAKE_VALID_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RESET_WRITE_CYC =
    (T_RESET_WRITE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SETUP_CYC  = (T_SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned STROBE_CYC = (T_STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned ACCESS_CYC = (T_ACCESS_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CNT_W      = 8;
  // Command codes
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_READ_ID     = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY  = 8'h98;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_PROGRAM     = 8'h40;
  localparam logic [7:0] CMD_ERASE       = 8'h20;
  localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
  localparam logic [7:0] CMD_SET_LOCK    = 8'h60;
  localparam logic [7:0] CMD_LOCK_CONF   = 8'h01;
  // Identifier word addresses
  localparam logic [ADDR_W-1:0] ID_MFR_ADDR  = 22'h00_0000;
  localparam logic [ADDR_W-1:0] ID_DEV_ADDR  = 22'h00_0001;
  localparam logic [ADDR_W-1:0] ID_LOCK_OFS  = 22'h00_0002;
  localparam logic [7:0] STATUS_READY_MASK   = 8'h80;
  // Host request kinds
  typedef enum logic [2:0] {
    FBIM_OP_READ,
    FBIM_OP_WRITE,
    FBIM_OP_READ_MODE,
    FBIM_OP_PROGRAM,
    FBIM_OP_ERASE,
    FBIM_OP_SET_LOCK,
    FBIM_OP_POWERDOWN
  } fbim_op_t;
endpackage

/* testbench/fbim_flash_model.sv */
module fbim_flash_model
  import fbim_pkg::*;
#(
  parameter logic [15:0] MFR_CODE = 16'h0055, // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h00AA, // Arbitrary value
  parameter int          BUSY_CYC = 100
)
(
  input  wire logic              clk_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic              cs0_n_in,
  input  wire logic              cs1_n_in,
  input  wire logic              oe_n_in,
  input  wire logic              we_n_in,
  input  wire logic              pdn_n_in,
  input  wire logic              byte_n_in,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   busy_indicator_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_r [256];
  logic [15:0] q;
  logic [15:0] last_r;
  logic [15:0] d_r;
  logic [7:0]  a_r;
  logic [1:0]  mode_r = 2'h0;
  logic [1:0]  pend_r = 2'h0;
  logic        wr_r = 1'b0;
  logic        lock_r = 1'b0;
  int          busy_r = 0;
  wire wr = !we_n_in && !cs0_n_in && !cs1_n_in && oe_n_in && pdn_n_in;
  wire sel = !cs0_n_in && !cs1_n_in && !oe_n_in && pdn_n_in;
  initial
    for (int i = 0; i < 256; i++) mem_r[i] = {8'hC3, i[7:0]};
  always_comb
    case (mode_r)
      2'h0: q = mem_r[addr_in[7:0]];
      2'h1: q = addr_in == 0 ? MFR_CODE : addr_in == 1 ? DEV_CODE :
                addr_in[1:0] == 2'h2 ? {15'h0, lock_r} : 16'h0;
      2'h2: q = busy_r == 0 ? 16'h0080 : 16'h0000;
      default: q = 16'h0000;
    endcase
  // Released lines show the inverse of the last bus value, never a lucky match
  assign dq_out = !sel ? ~last_r : byte_n_in ? q : {~last_r[15:8], q[7:0]};
  assign busy_indicator_out = busy_r == 0;
  always @(posedge clk_in)
  begin
    last_r <= dq_in;
    wr_r <= wr;
    if (wr)
    begin
      a_r <= addr_in[7:0];
      d_r <= dq_in;
    end
    if (busy_r != 0)
      busy_r <= busy_r - 1;
    if (!pdn_n_in)
    begin
      mode_r <= 2'h0;
      pend_r <= 2'h0;
      // An aborted algorithm keeps busy low until two cycles after power-down ends
      busy_r <= busy_r != 0 ? 2 : 0;
    end
    else if (wr_r && !wr)
    begin
      pend_r <= 2'h0;
      case (pend_r)
        2'h1: mem_r[a_r] <= d_r;
        2'h2: if (d_r[7:0] == CMD_CONFIRM) for (int i = 0; i < 256; i++) mem_r[i] <= 16'hFFFF;
        2'h3: if (d_r[7:0] == CMD_LOCK_CONF) lock_r <= 1'b1;
        default: ;
      endcase
      if (pend_r != 2'h0)
      begin
        busy_r <= BUSY_CYC;
        mode_r <= 2'h2;
      end
      else
        case (d_r[7:0])
          CMD_READ_ARRAY: mode_r <= 2'h0;
          CMD_READ_ID: mode_r <= 2'h1;
          CMD_READ_STATUS: mode_r <= 2'h2;
          CMD_READ_QUERY: mode_r <= 2'h3;
          CMD_PROGRAM: pend_r <= 2'h1;
          CMD_ERASE: pend_r <= 2'h2;
          CMD_SET_LOCK: pend_r <= 2'h3;
          default: ;
        endcase
    end
  end
endmodule

/* testbench/fbim_host_assertions.sv */
module fbim_host_checker
  import fbim_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              sys_rst_in,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [DATA_W-1:0] data_lines_out,
  input wire logic              data_lines_oe_out,
  input wire logic              chip_select0_n_out,
  input wire logic              chip_select1_n_out,
  input wire logic              output_enable_n_out,
  input wire logic              write_enable_n_out,
  input wire logic              reset_powerdown_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire we = write_enable_n_out;
  wire oe = output_enable_n_out;
  wire pwr = reset_powerdown_n_out;
  wire cs = chip_select0_n_out;
  logic [7:0] wake_r;
  logic [7:0] wake_nxt;
  // Saturates so a long idle spell cannot wrap below the limit
  always_comb wake_nxt = !pwr ? 8'h00 : (wake_r == 8'hFF ? wake_r : wake_r + 8'h01);
  always_ff @(posedge clk_in) wake_r <= wake_nxt;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  a_oe_we_apart: assert property (oe || we)
    else $error("oe and we low together");
  a_write_select: assert property (!we |-> !cs && !chip_select1_n_out && oe)
    else $error("write strobe without select");
  a_write_drive: assert property (!we |-> data_lines_oe_out && pwr)
    else $error("write strobe without data drive");
  a_read_pins: assert property (!oe |-> !data_lines_oe_out && we && pwr)
    else $error("read with wrong pins");
  a_select_pair: assert property (cs == chip_select1_n_out)
    else $error("selects differ");
  a_latch_stable: assert property (!we |=> $stable(addr_out) && $stable(data_lines_out))
    else $error("address or data moved at strobe end");
  a_strobe_setup: assert property ($fell(we) |-> !$past(cs) && $past(data_lines_oe_out))
    else $error("no setup before strobe");
  a_reset_pulse: assert property ($rose(pwr) |-> !$past(pwr, RESET_LOW_CYC))
    else $error("power-down pulse too short");
  a_write_wake: assert property ($fell(we) |-> wake_r >= RESET_WRITE_CYC)
    else $error("write too soon after wake");
endmodule

bind fbim_host fbim_host_checker u_chk (
  .clk_in, .sys_rst_in, .addr_out, .data_lines_out, .data_lines_oe_out, .chip_select0_n_out,
  .chip_select1_n_out, .output_enable_n_out, .write_enable_n_out, .reset_powerdown_n_out
);

/* testbench/fbim_host_bench.sv */
module fbim_host_bench;
  import fbim_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MFR = 16'h0055; // Arbitrary value
  localparam logic [15:0] DEV = 16'h00AA; // Arbitrary value
  logic              clk_in = 1'b0;
  logic              sys_rst_in = 1'b1;
  logic              req_valid_in = 1'b0;
  fbim_op_t          req_op_in = FBIM_OP_READ;
  logic [ADDR_W-1:0] req_addr_in = '0;
  logic [DATA_W-1:0] req_data_in = '0;
  logic              byte_mode_in = 1'b0;
  logic              req_ready_out, rsp_valid_out, busy_seen_out, data_lines_oe_out;
  logic [DATA_W-1:0] rsp_data_out, data_lines_out, data_lines_in, dev_dq;
  logic [ADDR_W-1:0] addr_out;
  logic              chip_select0_n_out, chip_select1_n_out, output_enable_n_out;
  logic              write_enable_n_out, reset_powerdown_n_out, byte_width_select_n_out;
  logic              busy_indicator_in;
  int                n_errors = 0;
  int                checks_done = 0;
  int                cycles = 0;
  assign data_lines_in = data_lines_oe_out ? data_lines_out : dev_dq;
  fbim_host DUT (
    .clk_in, .sys_rst_in, .req_valid_in, .req_op_in, .req_addr_in, .req_data_in, .byte_mode_in,
    .req_ready_out, .rsp_valid_out, .rsp_data_out, .busy_seen_out, .addr_out, .data_lines_out,
    .data_lines_oe_out, .data_lines_in, .chip_select0_n_out, .chip_select1_n_out,
    .output_enable_n_out, .write_enable_n_out, .reset_powerdown_n_out,
    .byte_width_select_n_out, .busy_indicator_in);
  fbim_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .BUSY_CYC(100)) u_flash (
    .clk_in, .addr_in(addr_out), .dq_in(data_lines_in), .cs0_n_in(chip_select0_n_out),
    .cs1_n_in(chip_select1_n_out), .oe_n_in(output_enable_n_out),
    .we_n_in(write_enable_n_out), .pdn_n_in(reset_powerdown_n_out),
    .byte_n_in(byte_width_select_n_out), .dq_out(dev_dq),
    .busy_indicator_out(busy_indicator_in));
  always #10 clk_in = ~clk_in;
  task summarize;
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_errors++;
      summarize;
    end
  end
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task tick;
    @(posedge clk_in);
    #1;
  endtask
  task req(input fbim_op_t op, input logic [21:0] a, input logic [15:0] d);
    int k;
    k = 0;
    tick;
    while (req_ready_out !== 1'b1 && k < 500)
    begin
      tick;
      k++;
    end
    chk("ready", 16'h0001, 16'(req_ready_out));
    req_op_in = op;
    req_addr_in = a;
    req_data_in = d;
    req_valid_in = 1'b1;
    tick;
    req_valid_in = 1'b0;
  endtask
  task rd(input logic [21:0] a, input logic [15:0] exp);
    int k;
    req(FBIM_OP_READ, a, 16'h0000);
    k = 0;
    while (rsp_valid_out !== 1'b1 && k < 100)
    begin
      tick;
      k++;
    end
    chk("rsp valid", 16'h0001, 16'(rsp_valid_out));
    chk($sformatf("read %h", a), exp, rsp_data_out);
  endtask
  task mode(input logic [7:0] c);
    req(FBIM_OP_READ_MODE, 22'h00_3000, {8'h00, c});
  endtask
  task busy(input logic [15:0] exp);
    int k;
    k = 0;
    repeat (4) tick;
    while (busy_seen_out !== exp[0] && k < 300)
    begin
      tick;
      k++;
    end
    chk("busy seen", exp, 16'(busy_seen_out));
  endtask
  task t_program;
    rd(22'h00_0005, 16'hC305);
    req(FBIM_OP_PROGRAM, 22'h00_0007, 16'h1234);
    busy(16'h0001);
    mode(CMD_READ_STATUS);
    rd(22'h00_0000, 16'h0000);
    busy(16'h0000);
    rd(22'h00_0000, 16'h0080);
    mode(CMD_READ_ARRAY);
    rd(22'h00_0007, 16'h1234);
  endtask
  task t_ident;
    mode(CMD_READ_ID);
    rd(ID_MFR_ADDR, MFR);
    rd(ID_DEV_ADDR, DEV);
    rd(ID_LOCK_OFS, 16'h0000);
    req(FBIM_OP_SET_LOCK, 22'h00_0102, 16'h0000);
    busy(16'h0001);
    busy(16'h0000);
    mode(CMD_READ_ID);
    rd(ID_LOCK_OFS, 16'h0001);
  endtask
  task t_byte;
    byte_mode_in = 1'b1;
    mode(CMD_READ_ARRAY);
    rd(22'h00_0007, 16'h0034);
    chk("byte select", 16'h0000, 16'(byte_width_select_n_out));
    byte_mode_in = 1'b0;
  endtask
  task t_abort;
    req(FBIM_OP_ERASE, 22'h00_0009, 16'h0000);
    busy(16'h0001);
    req(FBIM_OP_POWERDOWN, 22'h00_0000, 16'h0000);
    rd(22'h00_0009, 16'hFFFF);
    chk("busy seen", 16'h0000, 16'(busy_seen_out));
    mode(CMD_READ_STATUS);
    rd(22'h00_0000, 16'h0080);
  endtask
  initial
  begin
    repeat (4) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    t_program;
    t_ident;
    t_byte;
    t_abort;
    summarize;
  end
endmodule

/* verilog/fbim_delay.sv */
module fbim_delay
  import fbim_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             start_in,
  input  wire logic [CNT_W-1:0] count_in,
  output logic                  done_out
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             done_r;
  logic             done_nxt;

  always_comb
  begin
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (start_in)
      cnt_nxt = count_in;
    else if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - 1'b1;
      done_nxt = (cnt_r == 8'h01);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_out = done_r;
endmodule

/* verilog/fbim_host.sv */
// Functional notes
// - Write needs WE, both selects low, OE high
// - Write read-mode command before reading
// - Read: selects and OE low, WE/reset high
// - Hold reset low, wait wake time before read
// - Wait reset-to-write delay before writing
// - Erase/lock use block address, program location
// - Issue read array after alteration completes
// - Share reset with host processor reset
// - Never OE and WE low together
module fbim_host
  import fbim_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              req_valid_in,
  input  wire fbim_op_t          req_op_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic [DATA_W-1:0] req_data_in,
  input  wire logic              byte_mode_in,
  output logic                   req_ready_out,
  output logic                   rsp_valid_out,
  output logic [DATA_W-1:0]      rsp_data_out,
  output logic                   busy_seen_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic [DATA_W-1:0]      data_lines_out,
  output logic                   data_lines_oe_out,
  input  wire logic [DATA_W-1:0] data_lines_in,
  output logic                   chip_select0_n_out,
  output logic                   chip_select1_n_out,
  output logic                   output_enable_n_out,
  output logic                   write_enable_n_out,
  output logic                   reset_powerdown_n_out,
  output logic                   byte_width_select_n_out,
  input  wire logic              busy_indicator_in
);
  typedef enum logic [3:0] {
    FBIM_S_RST_LOW, FBIM_S_WAKE, FBIM_S_IDLE, FBIM_S_WR_SETUP, FBIM_S_WR_STROBE,
    FBIM_S_WR_HOLD, FBIM_S_RD_ACCESS, FBIM_S_RD_DONE, FBIM_S_GAP, FBIM_S_BOOT
  } fbim_state_t;

  fbim_state_t       st_r, st_nxt;
  logic              second_r, second_nxt;
  logic [7:0]        conf_r, conf_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdat_r, wdat_nxt;
  logic              oe_r, oe_nxt, we_r, we_nxt, cs_r, cs_nxt, dq_oe_r, dq_oe_nxt;
  logic              pwr_r, pwr_nxt, rv_r, rv_nxt, rdy_r, rdy_nxt;
  logic [DATA_W-1:0] rdat_r, rdat_nxt;
  logic              byte_r;
  logic              busy_s1_r, busy_s2_r;
  logic [DATA_W-1:0] dq_s1_r, dq_s2_r;
  logic              tmr_start;
  logic [CNT_W-1:0]  tmr_count;
  logic              tmr_done;
  logic              busy_seen_r;

  fbim_delay u_delay (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .start_in   (tmr_start),
    .count_in   (tmr_count),
    .done_out   (tmr_done)
  );

  always_comb
  begin
    st_nxt     = st_r;
    second_nxt = second_r;
    conf_nxt   = conf_r;
    addr_nxt   = addr_r;
    wdat_nxt   = wdat_r;
    oe_nxt     = oe_r;
    we_nxt     = we_r;
    cs_nxt     = cs_r;
    dq_oe_nxt  = dq_oe_r;
    pwr_nxt    = pwr_r;
    rv_nxt     = 1'b0;
    rdy_nxt    = 1'b0;
    rdat_nxt   = rdat_r;
    tmr_start  = 1'b0;
    tmr_count  = '0;
    case (st_r)
      FBIM_S_BOOT:
      begin
        st_nxt    = FBIM_S_RST_LOW;
        tmr_start = 1'b1;
        tmr_count = CNT_W'(RESET_LOW_CYC);
      end
      FBIM_S_RST_LOW:
      begin
        // Reset shared with this host's reset so the part wakes into array reads
        if (tmr_done)
        begin
          pwr_nxt   = 1'b1;
          st_nxt    = FBIM_S_WAKE;
          tmr_start = 1'b1;
          tmr_count = CNT_W'(RESET_WRITE_CYC);
        end
      end
      FBIM_S_WAKE:
      begin
        // Write delay exceeds wake time, so one wait covers both
        if (tmr_done)
        begin
          st_nxt  = FBIM_S_IDLE;
          rdy_nxt = 1'b1;
        end
      end
      FBIM_S_IDLE:
      begin
        rdy_nxt = 1'b1;
        if (req_valid_in)
        begin
          rdy_nxt  = 1'b0;
          addr_nxt = req_addr_in;
          case (req_op_in)
            FBIM_OP_READ:
            begin
              // Selects and OE low only; WE stays high so never both low
              cs_nxt    = 1'b1;
              oe_nxt    = 1'b1;
              st_nxt    = FBIM_S_RD_ACCESS;
              tmr_start = 1'b1;
              tmr_count = CNT_W'(ACCESS_CYC);
            end
            FBIM_OP_POWERDOWN:
            begin
              // Aborts any running alteration
              pwr_nxt   = 1'b0;
              st_nxt    = FBIM_S_BOOT;
            end
            default:
            begin
              // Mode writes take one cycle, alterations two
              second_nxt = (req_op_in == FBIM_OP_PROGRAM) || (req_op_in == FBIM_OP_ERASE)
                           || (req_op_in == FBIM_OP_SET_LOCK);
              case (req_op_in)
                FBIM_OP_PROGRAM:  wdat_nxt = {req_data_in[15:8], CMD_PROGRAM};
                FBIM_OP_ERASE:    wdat_nxt = {8'h00, CMD_ERASE};
                FBIM_OP_SET_LOCK: wdat_nxt = {8'h00, CMD_SET_LOCK};
                default:          wdat_nxt = req_data_in;
              endcase
              conf_nxt = (req_op_in == FBIM_OP_PROGRAM) ? req_data_in[7:0]
                       : (req_op_in == FBIM_OP_ERASE) ? CMD_CONFIRM : CMD_LOCK_CONF;
              cs_nxt    = 1'b1;
              dq_oe_nxt = 1'b1;
              st_nxt    = FBIM_S_WR_SETUP;
              tmr_start = 1'b1;
              tmr_count = CNT_W'(SETUP_CYC);
            end
          endcase
        end
      end
      FBIM_S_WR_SETUP:
      begin
        // OE already high; WE falls with selects held low
        if (tmr_done)
        begin
          we_nxt    = 1'b1;
          st_nxt    = FBIM_S_WR_STROBE;
          tmr_start = 1'b1;
          tmr_count = CNT_W'(STROBE_CYC);
        end
      end
      FBIM_S_WR_STROBE:
      begin
        // WE rises before selects so the device latches on WE
        if (tmr_done)
        begin
          we_nxt = 1'b0;
          st_nxt = FBIM_S_WR_HOLD;
        end
      end
      FBIM_S_WR_HOLD:
      begin
        cs_nxt    = 1'b0;
        dq_oe_nxt = 1'b0;
        if (second_r)
        begin
          second_nxt     = 1'b0;
          wdat_nxt[7:0]  = conf_r;
          cs_nxt         = 1'b1;
          dq_oe_nxt      = 1'b1;
          st_nxt         = FBIM_S_WR_SETUP;
          tmr_start      = 1'b1;
          tmr_count      = CNT_W'(SETUP_CYC);
        end
        else
          st_nxt = FBIM_S_GAP;
      end
      FBIM_S_RD_ACCESS:
      begin
        if (tmr_done)
          st_nxt = FBIM_S_RD_DONE;
      end
      FBIM_S_RD_DONE:
      begin
        // Byte mode returns only the low eight lines
        rdat_nxt = byte_r ? {8'h00, dq_s2_r[7:0]} : dq_s2_r;
        rv_nxt   = 1'b1;
        oe_nxt   = 1'b0;
        cs_nxt   = 1'b0;
        st_nxt   = FBIM_S_GAP;
      end
      FBIM_S_GAP:
      begin
        st_nxt  = FBIM_S_IDLE;
        rdy_nxt = 1'b1;
      end
      default:
        st_nxt = FBIM_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      st_r              <= FBIM_S_BOOT;
      second_r          <= 1'b0;
      conf_r            <= 8'h00;
      addr_r            <= '0;
      wdat_r            <= '0;
      oe_r              <= 1'b0;
      we_r              <= 1'b0;
      cs_r              <= 1'b0;
      dq_oe_r           <= 1'b0;
      pwr_r             <= 1'b0;
      rv_r              <= 1'b0;
      rdy_r             <= 1'b0;
      rdat_r            <= '0;
      busy_seen_r       <= 1'b0;
      byte_r            <= 1'b0;
      busy_s1_r         <= 1'b0;
      busy_s2_r         <= 1'b0;
      dq_s1_r           <= '0;
      dq_s2_r           <= '0;
    end
    else
    begin
      st_r              <= st_nxt;
      second_r          <= second_nxt;
      conf_r            <= conf_nxt;
      addr_r            <= addr_nxt;
      wdat_r            <= wdat_nxt;
      oe_r              <= oe_nxt;
      we_r              <= we_nxt;
      cs_r              <= cs_nxt;
      dq_oe_r           <= dq_oe_nxt;
      pwr_r             <= pwr_nxt;
      rv_r              <= rv_nxt;
      rdy_r             <= rdy_nxt;
      rdat_r            <= rdat_nxt;
      busy_seen_r       <= ~busy_s2_r & pwr_r;
      byte_r            <= byte_mode_in;
      busy_s1_r         <= busy_indicator_in;
      busy_s2_r         <= busy_s1_r;
      dq_s1_r           <= data_lines_in;
      dq_s2_r           <= dq_s1_r;
    end
  end

  // Select, OE, WE and byte pins are active-low inversions of registered enables; reset-powerdown follows pwr_r directly
  always_comb
  begin
    addr_out                = addr_r;
    data_lines_out          = wdat_r;
    data_lines_oe_out       = dq_oe_r;
    chip_select0_n_out      = ~cs_r;
    chip_select1_n_out      = ~cs_r;
    output_enable_n_out     = ~oe_r;
    write_enable_n_out      = ~we_r;
    reset_powerdown_n_out   = pwr_r;
    byte_width_select_n_out = ~byte_r;
    req_ready_out           = rdy_r;
    rsp_valid_out           = rv_r;
    rsp_data_out            = rdat_r;
    // Level-mode busy pin is low while an algorithm runs, so busy_seen_out is high then
    busy_seen_out           = busy_seen_r;
  end
endmodule
